// *** core/odac_params.svh ***
// constants of the octal dac serial slave port
// assumes: included by bare name from the design file only
`ifndef ODAC_PARAMS_SVH
`define ODAC_PARAMS_SVH

`define ODAC_ADDR_UPPER    5'h15
`define ODAC_ADDR_W        7
`define ODAC_FRAME_BYTES   2'h3
`define ODAC_LAST_BIT      3'h7
`define ODAC_CMD_MSB       23
`define ODAC_CMD_LSB       20
`define ODAC_CHAN_MSB      19
`define ODAC_CHAN_LSB      16
`define ODAC_DATA_MSB      15
`define ODAC_CMD_REF       4'h8
`define ODAC_CHAN_ALL      4'hf
`define ODAC_CHAN_LAST     4'h7
`define ODAC_REF_ON_BIT    0
`define ODAC_REF_SEL_BIT   1
`define ODAC_REF_ON_RST    1'b0
`define ODAC_REF_SEL_RST   1'b0
`define ODAC_CLK_NS        10
`define ODAC_SCL_FAST_NS   2500
`define ODAC_SCL_STD_NS    10000
`define ODAC_MIN_OVERSAMP  4

`endif

// *** core/odac_pkg.sv ***
// types shared by the octal dac serial slave port
// assumes: widths written out here, odac_params.svh is not included
package odac_pkg;

  typedef enum logic [2:0] {
    ODAC_IDLE    = 3'b000,
    ODAC_ADDR    = 3'b001,
    ODAC_ACK_ADR = 3'b010,
    ODAC_WR_BYTE = 3'b011,
    ODAC_WR_ACK  = 3'b100,
    ODAC_RD_BYTE = 3'b101,
    ODAC_RD_ACK  = 3'b110,
    ODAC_IGNORE  = 3'b111
  } odac_state_e;

  // three-state strap as seen by the pad detector
  typedef enum logic [1:0] {
    ODAC_STRAP_SUPPLY = 2'b00,
    ODAC_STRAP_OPEN   = 2'b01,
    ODAC_STRAP_GROUND = 2'b10
  } odac_strap_e;

  typedef struct packed {
    logic [3:0]  cmd;
    logic [3:0]  chan;
    logic [15:0] data;
  } odac_frame_s;

endpackage

// *** core/odac_i2c_slave.sv ***
// serial slave port of an octal voltage-output dac
// assumes: scl/sda already synchronous to clk_sys, open-drain wire resolved
// outside, strap state supplied by a three-level pad detector
//
// What this block does
// - data word is unsigned straight binary, output scales as code over 2^N.
// - latch codes 0..4095 at 12 bits or 0..65535 at 16 bits.
// - internal reference is off after reset.
// - internal reference turns on only via the reference-control command.
// - port works at 100 kHz and 400 kHz bus clock.
// - ignore 10-bit and general call addresses; answer own address only.
// - address upper five bits are 10101, low two from the strap.
// - strap supply gives 00, open gives 10, ground gives 11.
// - transfer starts with a start, then address plus read/write byte.
// - on address match pull sda low during the ninth pulse.
// - on mismatch go to the ignore state, busy stays high, sda released until next stop or start.
// - nine pulses per byte, msb first; sda changes only with scl low.
// - acknowledge each of the three written bytes on its ninth pulse.
// - read shifts out three bytes; master acks the first two.
// - word bits 23:20 command, 19:16 channel, rest data.
// - channel 0..7 select one channel, 15 selects all.
// - command 1000 sets reference: data bit 0 on, bit 1 value.
`timescale 1ns/1ps
`default_nettype none
`include "odac_params.svh"

module odac_i2c_slave #(
  parameter int RESOLUTION = 16
) (
  // clock and reset
  input  wire logic                      clk_sys,
  input  wire logic                      sys_rst,
  // serial bus, open drain
  input  wire logic                      scl_in,
  input  wire logic                      sda_in,
  output logic                           sda_out,
  output logic                           sda_oe,
  // address strap
  input  wire odac_pkg::odac_strap_e     address_select_strap,
  // readback word from the dac register logic
  input  wire odac_pkg::odac_frame_s     rd_word,
  // write frame towards the dac register logic
  output logic                           wr_strobe,
  output odac_pkg::odac_frame_s          wr_frame,
  output logic [7:0]                     wr_chan_mask,
  output logic [RESOLUTION-1:0]          wr_code,
  // reference control
  output logic                           ref_enable,
  output logic                           ref_select,
  // status
  output logic                           busy,
  output logic [6:0]                     own_addr
);
  import odac_pkg::*;

  localparam int SCL_FAST_CYC = `ODAC_SCL_FAST_NS / `ODAC_CLK_NS;

  // refused at elaboration: the code path only knows these two widths
  if (RESOLUTION != 12 && RESOLUTION != 16) begin : g_bad_res
    $error("odac_i2c_slave: RESOLUTION must be 12 or 16");
  end
  // edge detection needs a few clk samples per fast-mode scl period
  if (SCL_FAST_CYC < `ODAC_MIN_OVERSAMP) begin : g_slow_clk
    $error("odac_i2c_slave: clock too slow for fast mode");
  end

  // strap decode to low address bits
  function automatic logic [1:0] strap_bits(input odac_strap_e s);
    case (s)
      ODAC_STRAP_SUPPLY: strap_bits = 2'h0;
      ODAC_STRAP_OPEN:   strap_bits = 2'h2;
      ODAC_STRAP_GROUND: strap_bits = 2'h3;
      default:           strap_bits = 2'h0;
    endcase
  endfunction

  odac_state_e state;
  odac_state_e next_state;
  logic        scl_prev;
  logic        sda_prev;
  logic [2:0]  bit_cnt;
  logic [1:0]  byte_cnt;
  logic [7:0]  shift;
  logic        rw_read;
  logic        drv_low;
  logic        strap_taken;
  logic        start_seen;
  logic [15:0] data_hi_lo;
  logic [3:0]  cmd_chan_cmd;
  logic [3:0]  cmd_chan_ch;
  logic [23:0] tx_word;

  // bus condition decode
  wire scl_rise   = scl_in & ~scl_prev;
  wire scl_fall   = ~scl_in & scl_prev;
  wire start_cond = scl_in & scl_prev & sda_prev & ~sda_in;
  wire stop_cond  = scl_in & scl_prev & ~sda_prev & sda_in;
  wire byte_done  = bit_cnt == `ODAC_LAST_BIT;
  // 7-bit match only: general call 0x00 and 10-bit 11110xx never match
  wire addr_match = shift[7:1] == own_addr;
  wire last_byte  = byte_cnt == (`ODAC_FRAME_BYTES - 2'h1);
  wire [7:0] rd_byte = (byte_cnt == 2'h0) ? tx_word[23:16] :
                       (byte_cnt == 2'h1) ? tx_word[15:8]  :
                                            tx_word[7:0];
  // low byte is captured on the fall ending it, before the commit fall
  wire [23:0] full_word = {cmd_chan_cmd, cmd_chan_ch, data_hi_lo};

  // open drain: only ever pull low
  assign sda_out = 1'b0;
  assign sda_oe  = drv_low;

  // strap caught once, on the first edge after reset release
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      strap_taken <= 1'b0;
      own_addr    <= 7'h00;
    end else if (!strap_taken) begin
      strap_taken <= 1'b1;
      own_addr    <= {`ODAC_ADDR_UPPER,
                      strap_bits(address_select_strap)};
    end
  end

  always_comb begin
    next_state = state;
    if (start_cond) begin
      next_state = ODAC_ADDR;
    end else if (stop_cond) begin
      next_state = ODAC_IDLE;
    end else if (scl_fall) begin
      case (state)
        ODAC_ADDR:
          if (byte_done)
            next_state = addr_match ? ODAC_ACK_ADR
                                    : ODAC_IGNORE;
        ODAC_ACK_ADR:
          next_state = rw_read ? ODAC_RD_BYTE : ODAC_WR_BYTE;
        ODAC_WR_BYTE:
          if (byte_done)
            next_state = ODAC_WR_ACK;
        ODAC_WR_ACK:
          next_state = last_byte ? ODAC_IGNORE : ODAC_WR_BYTE;
        ODAC_RD_BYTE:
          if (byte_done)
            next_state = ODAC_RD_ACK;
        ODAC_RD_ACK:
          next_state = ODAC_RD_BYTE;
        ODAC_IDLE:   next_state = ODAC_IDLE;
        ODAC_IGNORE: next_state = ODAC_IGNORE;
        default:     next_state = ODAC_IDLE;
      endcase
    end else if (scl_rise && state == ODAC_RD_ACK && sda_in) begin
      next_state = ODAC_IGNORE;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      state    <= ODAC_IDLE;
      busy     <= 1'b0;
      scl_prev <= 1'b1;
      sda_prev <= 1'b1;
    end else begin
      state    <= next_state;
      busy     <= next_state != ODAC_IDLE; // same timing as the state
      scl_prev <= scl_in;
      sda_prev <= sda_in;
    end
  end

  // the master pulls scl low right after a start; that fall is no bit
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      start_seen <= 1'b0;
    end else if (start_cond) begin
      start_seen <= 1'b1;
    end else if (scl_fall) begin
      start_seen <= 1'b0;
    end
  end

  // bit and byte counting, shifting in on the rising edge
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      bit_cnt  <= 3'h0;
      byte_cnt <= 2'h0;
      shift    <= 8'h00;
      rw_read  <= 1'b0;
    end else if (start_cond) begin
      bit_cnt  <= 3'h0;
      byte_cnt <= 2'h0;
    end else if (scl_rise && (state == ODAC_ADDR ||
                              state == ODAC_WR_BYTE)) begin
      shift <= {shift[6:0], sda_in};
    end else if (scl_fall) begin
      case (state)
        ODAC_ADDR: begin
          // otherwise the address would be judged one bit early
          if (!start_seen)
            bit_cnt <= bit_cnt + 3'h1;
          if (byte_done)
            rw_read <= shift[0];
        end
        ODAC_WR_BYTE, ODAC_RD_BYTE:
          bit_cnt <= bit_cnt + 3'h1;
        ODAC_WR_ACK, ODAC_RD_ACK:
          byte_cnt <= byte_cnt + 2'h1;
        default:
          bit_cnt <= bit_cnt;
      endcase
    end
  end

  // sda drive changes on the falling scl edge; a start or stop condition releases it
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      drv_low <= 1'b0;
      tx_word <= 24'h000000;
    end else if (start_cond || stop_cond) begin
      drv_low <= 1'b0;
    end else if (scl_fall) begin
      case (state)
        ODAC_ADDR:
          drv_low <= byte_done & addr_match;
        ODAC_ACK_ADR: begin
          drv_low <= rw_read & ~rd_word.cmd[3];
          // frozen here so a later update cannot tear a read frame
          tx_word <= rd_word;
        end
        ODAC_WR_BYTE:
          drv_low <= byte_done;
        ODAC_RD_BYTE:
          drv_low <= byte_done ? 1'b0
                               : ~rd_byte[3'h6 - bit_cnt];
        ODAC_RD_ACK: begin
          drv_low <= 1'b0;
          if (!last_byte)
            drv_low <= ~(byte_cnt == 2'h0 ? tx_word[15] : tx_word[7]);
        end
        default:
          drv_low <= 1'b0;
      endcase
    end
  end

  // capture command and data bytes; commit after the third ack
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      cmd_chan_cmd <= 4'h0;
      cmd_chan_ch  <= 4'h0;
      data_hi_lo   <= 16'h0000;
    end else if (scl_fall && state == ODAC_WR_BYTE && byte_done) begin
      if (byte_cnt == 2'h0)
        {cmd_chan_cmd, cmd_chan_ch} <= shift;
      if (byte_cnt == 2'h1)
        data_hi_lo[15:8] <= shift;
      if (byte_cnt == 2'h2)
        data_hi_lo[7:0] <= shift;
    end
  end

  // a stop inside the third ack still discards the frame
  wire commit = scl_fall && state == ODAC_WR_ACK && last_byte;
  wire [3:0] commit_cmd  = data_frame_cmd(full_word);
  wire [3:0] commit_chan = full_word[`ODAC_CHAN_MSB:`ODAC_CHAN_LSB];
  wire [7:0] chan_mask   = (commit_chan == `ODAC_CHAN_ALL) ? 8'hff :
                           (commit_chan <= `ODAC_CHAN_LAST) ?
                           8'h01 << commit_chan[2:0] : 8'h00;

  function automatic logic [3:0] data_frame_cmd(input logic [23:0] w);
    data_frame_cmd = w[`ODAC_CMD_MSB:`ODAC_CMD_LSB];
  endfunction

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      wr_strobe    <= 1'b0;
      wr_frame     <= '0;
      wr_chan_mask <= 8'h00;
      wr_code      <= '0;
      ref_enable   <= `ODAC_REF_ON_RST;
      ref_select   <= `ODAC_REF_SEL_RST;
    end else begin
      wr_strobe <= commit;
      if (commit) begin
        wr_frame     <= full_word;
        wr_chan_mask <= chan_mask;
        // straight binary, 12-bit codes sit left aligned
        wr_code <= full_word[`ODAC_DATA_MSB -: RESOLUTION];
        if (commit_cmd == `ODAC_CMD_REF) begin
          ref_enable <= full_word[`ODAC_REF_ON_BIT];
          ref_select <= full_word[`ODAC_REF_SEL_BIT];
        end
      end
    end
  end

endmodule
`default_nettype wire

// *** sim/odac_i2c_slave_chk.sv ***
// port assertions for the dac serial slave port
// assumes: bound into odac_i2c_slave, one clock domain
`timescale 1ns/1ps
`default_nettype none
module odac_i2c_slave_chk import odac_pkg::*; #(
  parameter int RESOLUTION = 16
) (
  // clock, reset, bus
  input wire logic                  clk_sys,
  input wire logic                  sys_rst,
  input wire logic                  scl_in,
  input wire logic                  sda_in,
  input wire logic                  sda_out,
  input wire logic                  sda_oe,
  // dac side
  input wire odac_strap_e           address_select_strap,
  input wire odac_frame_s           rd_word,
  input wire logic                  wr_strobe,
  input wire odac_frame_s           wr_frame,
  input wire logic [7:0]            wr_chan_mask,
  input wire logic [RESOLUTION-1:0] wr_code,
  input wire logic                  ref_enable,
  input wire logic                  ref_select,
  input wire logic                  busy,
  input wire logic [6:0]            own_addr
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (sys_rst);
  wire logic [1:0] sb = address_select_strap == ODAC_STRAP_SUPPLY ? 2'h0
    : address_select_strap == ODAC_STRAP_OPEN ? 2'h2 : 2'h3;
  wire logic [7:0] em = wr_frame.chan == 4'hf ? 8'hff
    : wr_frame.chan[3] ? 8'h00 : 8'h01 << wr_frame.chan[2:0];
  // reset itself is the antecedent, so no disable here
  property p_rst;
    disable iff (1'b0) sys_rst |=> !sda_oe && !wr_strobe && !ref_enable;
  endproperty
  a_rst: assert property (p_rst) else $error("reset not quiet");
  property p_oerise; $rose(sda_oe) |-> !scl_in && !$past(scl_in); endproperty
  a_oerise: assert property (p_oerise) else $error("late pull");
  property p_oefall; $fell(sda_oe) |-> !scl_in; endproperty
  a_oefall: assert property (p_oefall) else $error("early release");
  property p_addr;
    !$past(sys_rst) |-> own_addr == {5'h15, $past(sb)};
  endproperty
  a_addr: assert property (p_addr) else $error("own address");
  property p_pulse; wr_strobe |=> !wr_strobe; endproperty
  a_pulse: assert property (p_pulse) else $error("long strobe");
  property p_fields;
    wr_strobe |-> wr_chan_mask == em &&
      wr_code == wr_frame.data[15 -: RESOLUTION];
  endproperty
  a_fields: assert property (p_fields) else $error("mask");
  property p_ref;
    wr_strobe && wr_frame.cmd == 4'h8 |->
      {ref_select, ref_enable} == wr_frame.data[1:0];
  endproperty
  a_ref: assert property (p_ref) else $error("ref update");
  property p_refkeep;
    $changed(ref_enable) |-> wr_strobe && wr_frame.cmd == 4'h8;
  endproperty
  a_refkeep: assert property (p_refkeep) else $error("ref moved");
endmodule
bind odac_i2c_slave odac_i2c_slave_chk #(.RESOLUTION(RESOLUTION)) u_chk (
  .clk_sys(clk_sys), .sys_rst(sys_rst), .scl_in(scl_in), .sda_in(sda_in),
  .sda_out(sda_out), .sda_oe(sda_oe),
  .address_select_strap(address_select_strap), .rd_word(rd_word),
  .wr_strobe(wr_strobe), .wr_frame(wr_frame), .wr_chan_mask(wr_chan_mask),
  .wr_code(wr_code), .ref_enable(ref_enable), .ref_select(ref_select),
  .busy(busy), .own_addr(own_addr));
`default_nettype wire

// *** sim/odac_master.sv ***
// bus master model, open-drain drive only
// assumes: bench resolves sda_bus from all drivers, pull-up high
`timescale 1ns/1ps
`default_nettype none
module odac_master #(
  parameter int HALF = 126 // about 397 kHz at 100 MHz
) (
  // clock and bus
  input  wire logic clk_sys,
  input  wire logic sda_bus,
  output var logic  scl,
  output var logic  sda_drv
);
  initial scl = 1'b1;
  initial sda_drv = 1'b1;
  task automatic wt(input int n);
    repeat (n) @(negedge clk_sys);
  endtask
  task automatic start_c;
    sda_drv = 1'b1;
    wt(HALF);
    scl = 1'b1;
    wt(HALF);
    sda_drv = 1'b0;
    wt(HALF);
    scl = 1'b0;
  endtask
  // data moves mid-low only
  task automatic bit_x(input logic b, output logic r);
    wt(HALF / 2);
    sda_drv = b;
    wt(HALF / 2);
    scl = 1'b1;
    wt(HALF / 2);
    r = sda_bus;
    wt(HALF / 2);
    scl = 1'b0;
  endtask
  task automatic xfer(input logic [7:0] d, input logic a,
                      output logic [7:0] q, output logic k);
    for (int i = 7; i >= 0; i--) bit_x(d[i], q[i]);
    bit_x(a, k);
  endtask
  // only after a whole byte, never inside the address
  task automatic stop_c;
    wt(HALF / 2);
    sda_drv = 1'b0;
    wt(HALF / 2);
    scl = 1'b1;
    wt(HALF);
    sda_drv = 1'b1;
    wt(HALF);
  endtask
endmodule
`default_nettype wire

// *** sim/octal_dac_i2c_slave_port_tb.sv ***
// self-checking bench for the dac serial slave port
// assumes: odac_master plays the bus master
`timescale 1ns/1ps
`default_nettype none
module octal_dac_i2c_slave_port_tb;
  import odac_pkg::*;
  logic        clk_sys = 1'b0;
  logic        sys_rst = 1'b1;
  logic        scl;
  logic        sda_drv;
  wire logic   sda_oe;
  wire logic   sda_out;
  // wired-and with pull-up: the device shows sda_out while enabled
  wire logic   sda_bus = sda_drv & (~sda_oe | sda_out);
  odac_strap_e strap = ODAC_STRAP_SUPPLY;
  odac_frame_s rd_word = '0;
  odac_frame_s wr_frame;
  odac_frame_s f;
  odac_frame_s ef;
  odac_frame_s exp_q[$];
  logic        wr_strobe, ref_enable, ref_select, busy;
  logic [7:0]  wr_chan_mask;
  logic [7:0]  em;
  logic [15:0] wr_code;
  logic [6:0]  own_addr;
  logic [1:0]  sb [3] = '{2'h0, 2'h2, 2'h3};
  int          err_total = 0;
  int          tests_run = 0;
  int          seed = 54;
  int          cyc = 0;
  always #5 clk_sys = ~clk_sys;
  odac_i2c_slave #(.RESOLUTION(16)) dut (.clk_sys(clk_sys),
    .sys_rst(sys_rst), .scl_in(scl), .sda_in(sda_bus), .sda_out(sda_out),
    .sda_oe(sda_oe), .address_select_strap(strap), .rd_word(rd_word),
    .wr_strobe(wr_strobe), .wr_frame(wr_frame), .wr_chan_mask(wr_chan_mask),
    .wr_code(wr_code), .ref_enable(ref_enable), .ref_select(ref_select),
    .busy(busy), .own_addr(own_addr));
  odac_master #(.HALF(126)) m (.clk_sys(clk_sys), .sda_bus(sda_bus),
    .scl(scl), .sda_drv(sda_drv));
  task automatic chk(input logic ok, input string what);
    tests_run++;
    if (ok !== 1'b1) begin
      err_total++;
      $display("Error at %0t: %s", $time, what);
    end
  endtask
  task automatic print_verdict;
    $display("checks %0d, errors %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  task automatic wr(input logic [6:0] a, input int n, input logic ack);
    logic [7:0] q;
    logic       k;
    if (ack && n == 3) exp_q.push_back(f);
    m.start_c();
    chk(busy === 1'b1, "busy after start");
    m.xfer({a, 1'b0}, 1'b1, q, k);
    chk(k === ~ack, "address ack");
    for (int i = 0; i < n && ack; i++) begin
      m.xfer(f[23 - 8 * i -: 8], 1'b1, q, k);
      chk(k === 1'b0, "data ack");
    end
    m.stop_c();
    chk(busy === 1'b0, "idle after stop");
  endtask
  task automatic rd(input logic [6:0] a);
    logic [7:0] q;
    logic       k;
    m.start_c();
    m.xfer({a, 1'b1}, 1'b1, q, k);
    chk(k === 1'b0, "read ack");
    for (int i = 0; i < 3; i++) begin
      m.xfer(8'hff, i == 2, q, k);
      chk(q === rd_word[23 - 8 * i -: 8], "read byte");
    end
    m.stop_c();
    chk(busy === 1'b0, "idle after read");
  endtask
  // commit monitor: oldest note against each strobe; the falling edge
  // keeps it clear of the edge that launches the registered outputs
  always @(negedge clk_sys) begin
    if (wr_strobe === 1'b1 && exp_q.size() == 0) begin
      chk(1'b0, "commit of a cut frame");
    end else if (wr_strobe === 1'b1) begin
      ef = exp_q.pop_front();
      em = ef.chan == 4'hf ? 8'hff : 8'h00;
      if (!ef.chan[3]) em = 8'h01 << ef.chan[2:0];
      chk(wr_frame === ef, "frame");
      chk(wr_chan_mask === em, "mask");
      chk(wr_code === ef.data, "code");
      if (ef.cmd == 4'h8)
        chk({ref_select, ref_enable} === ef.data[1:0], "ref");
    end
  end
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == 95000) begin
      chk(1'b0, "timeout");
      print_verdict();
    end
  end
  initial begin
    for (int s = 0; s < 3; s++) begin
      @(negedge clk_sys);
      sys_rst = 1'b1;
      strap = odac_strap_e'(s);
      repeat (3) @(negedge clk_sys);
      sys_rst = 1'b0;
      repeat (4) @(negedge clk_sys);
      chk(own_addr === {5'h15, sb[s]}, "address");
      chk(ref_enable === 1'b0, "ref at reset");
      // never a channel power-down command
      f = 24'($random(seed));
      f.cmd = s ? 4'h3 : 4'h8;
      f.data[0] = 1'b1;
      if (s == 1) f.chan = 4'hf;
      else f.chan[3] = 1'b0;
      wr({5'h15, sb[(s + 1) % 3]}, 3, 1'b0);
      wr({5'h15, sb[s]}, 3, 1'b1);
    end
    rd_word = 24'($random(seed));
    rd(7'h57);
    wr(7'h00, 3, 1'b0);
    wr(7'h78, 3, 1'b0);
    wr(7'h57, 2, 1'b1);
    f.data = 16'($random(seed));
    f.chan = 4'h9; // unused channel: empty mask, still a strobe
    wr(7'h57, 3, 1'b1);
    repeat (10) @(negedge clk_sys);
    chk(exp_q.size() == 0, "missing commit");
    print_verdict();
  end
endmodule
`default_nettype wire
